// *** src/pcm_slot_defines.svh ***
// Constants for the PCM slot and control port block.
`ifndef PCM_SLOT_DEFINES_SVH
`define PCM_SLOT_DEFINES_SVH

`define CTL_PWR_BIT 7
`define CTL_ADDR_HI 5
`define CTL_ADDR_LO 3
`define CTL_RD_BIT 2
`define CTL_TWO_BYTE_BIT 1
`define CTL_LAST_BIT 3'h7
`define ADDR_LATCH_VAL 3'h1
`define ADDR_LATCH_DIR 3'h2
`define LATCH_FIELD_HI 7
`define LATCH_FIELD_LO 4
`define LATCH_COUNT 4
`define LATCH_DIR_RST 4'h0
`define LATCH_VAL_RST 4'h0
`define PWR_DOWN_RST 1'b1
`define SLOT_CNT_W 10
`define SLOT_CNT_MAX 10'h3ff
`define SLOT_NUM_W 6
`define SLOT_LAST_BIT 3'h7
`define SYNC_W 11
`define SYNC_RST 11'h020

`endif

// *** src/pcm_slot_pkg.sv ***
// Types for the PCM slot and control port block.
`default_nettype none
package pcm_slot_pkg;

    typedef enum logic [3:0] {
        CTL_CMD   = 4'b0001,
        CTL_WRITE = 4'b0010,
        CTL_READ  = 4'b0100,
        CTL_DONE  = 4'b1000
    } ctl_phase_t;

    typedef struct packed {
        logic bclk_prev;
        logic control_clock_prev;
        logic tx_fs_rise_prev;
        logic tx_fs_fall_prev;
        logic tx_pend;
        logic [9:0] tx_cnt;
        logic [7:0] tx_byte;
        logic tx_out;
        logic tx_oe;
        logic tx_taken;
        logic rx_fs_rise_prev;
        logic rx_fs_fall_prev;
        logic rx_pend;
        logic [9:0] rx_cnt;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic rx_valid;
        ctl_phase_t ctl_phase;
        logic [2:0] ctl_bits;
        logic [7:0] ctl_cmd;
        logic [7:0] ctl_shift;
        logic ctl_oe;
        logic power_down;
        logic [3:0] latch_dir;
        logic [3:0] latch_val;
        logic wr_pulse;
        logic [2:0] wr_addr;
        logic [7:0] wr_data;
    } state_t;

endpackage
`default_nettype wire

// *** src/pin_sync.sv ***
// Three-stage input synchroniser that updates once the last two stages agree.
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Asynchronous inputs and their settled copies.
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("pin_sync needs WIDTH of at least 1.");
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ff1 <= RST_VAL;
            ff2 <= RST_VAL;
            ff3 <= RST_VAL;
            sync_o <= RST_VAL;
        end
        else
        begin
            ff1 <= async_i;
            ff2 <= ff1;
            ff3 <= ff2;
            for (int i = 0; i < WIDTH; i++)
            begin
                if (ff2[i] == ff3[i])
                begin
                    sync_o[i] <= ff3[i];
                end
            end
        end
    end

endmodule // pin_sync
`default_nettype wire

// *** src/pcm_slot_and_control_port.sv ***
// PCM time-slot shifter with serial control port and interface latches.
`include "pcm_slot_defines.svh"
`default_nettype none
// Behaviour
// [RL1] Transmit sync marks slot or frame start.
// [RL2] Receive sync marks slot or frame start.
// [RL3] Host supplies bit clock, 64 kHz-4.096 MHz.
// [RL4] Host supplies master clock at listed rates.
// [RL5] Transmit output floats outside assigned slot.
// [RL6] Transmit bits change on rising bit clock.
// [RL7] Slot strobe pulls low during transmit slot.
// [RL8] Receive samples falling edges, own slot only.
// [RL9] Control clock shifts only with select low.
// [RL10] First control byte is always a write.
// [RL11] First byte bit 2 selects read-back.
// [RL12] Control output drives while select low; code drives it only after a read command byte, until select rises.
// [RL13] Direction register sets each latch pin direction.
// [RL14] Input latches captured on each control write.
// [RL15] Output latches drive last written value.
// [RL16] Bit 7 shifts first on control lines.
// [RL17] First byte bit 7 selects power-down.
// [RL18] Power-down floats transmit output, control works.
// [RL19] Each slot carries exactly eight bits.
// [RL20] Control writes cross safely into core clock.
module pcm_slot_and_control_port (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Timing configuration.
    input wire logic delayed_timing_i,
    input wire logic [`SLOT_NUM_W-1:0] tx_slot_i,
    input wire logic [`SLOT_NUM_W-1:0] rx_slot_i,
    // PCM bus pins.
    input wire logic bit_clock_i,
    input wire logic transmit_frame_sync_i,
    input wire logic receive_frame_sync_i,
    input wire logic receive_pcm_in_i,
    output logic transmit_pcm_out_o,
    output logic transmit_pcm_out_oe_o,
    output logic transmit_slot_strobe_n_o,
    output logic transmit_slot_strobe_n_oe_o,
    // Sample side.
    input wire logic [7:0] tx_sample_i,
    output logic tx_sample_taken_o,
    output logic [7:0] rx_sample_o,
    output logic rx_sample_valid_o,
    // Serial control pins.
    input wire logic control_clock_i,
    input wire logic chip_select_n_i,
    input wire logic control_serial_in_i,
    output logic control_serial_out_o,
    output logic control_serial_out_oe_o,
    // Other control registers, held outside, and the power-down flag.
    input wire logic [7:0] ctl_read_data_i,
    output logic ctl_write_o,
    output logic [2:0] ctl_write_addr_o,
    output logic [7:0] ctl_write_data_o,
    output logic power_down_o,
    // Interface latch pins.
    input wire logic [`LATCH_COUNT-1:0] interface_latch_pins_i,
    output logic [`LATCH_COUNT-1:0] interface_latch_pins_o,
    output logic [`LATCH_COUNT-1:0] interface_latch_pins_oe_o
);

    pcm_slot_pkg::state_t s;
    pcm_slot_pkg::state_t next_s;
    logic [`SYNC_W-1:0] pins;
    logic bclk;
    logic transmit_frame_sync;
    logic receive_frame_sync;
    logic dr;
    logic control_clock;
    logic cs_n;
    logic ci;
    logic [`LATCH_COUNT-1:0] latch_in;

    // Synchronising the control clock brings every write into the core clock.
    // [RL20] Control clock crossing.
    pin_sync #(
        .WIDTH(`SYNC_W),
        .RST_VAL(`SYNC_RST)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({interface_latch_pins_i, control_serial_in_i, chip_select_n_i, control_clock_i,
                  receive_pcm_in_i, receive_frame_sync_i, transmit_frame_sync_i, bit_clock_i}),
        .sync_o(pins)
    );

    assign bclk = pins[0];
    assign transmit_frame_sync = pins[1];
    assign receive_frame_sync = pins[2];
    assign dr = pins[3];
    assign control_clock = pins[4];
    assign cs_n = pins[5];
    assign ci = pins[6];
    assign latch_in = pins[10:7];

    always_comb
    begin
        logic bclk_rise;
        logic bclk_fall;
        logic control_clock_fall;
        logic tx_start;
        logic rx_start;
        logic tx_act;
        logic rx_act;
        logic [`SLOT_NUM_W-1:0] tx_sel;
        logic [`SLOT_NUM_W-1:0] rx_sel;
        logic [7:0] sh;
        logic [3:0] captured;
        logic [7:0] rd;
        bclk_rise = bclk && !s.bclk_prev;
        bclk_fall = !bclk && s.bclk_prev;
        control_clock_fall = !control_clock && s.control_clock_prev;
        tx_start = 1'b0;
        rx_start = 1'b0;
        tx_act = 1'b0;
        rx_act = 1'b0;
        tx_sel = delayed_timing_i ? tx_slot_i : '0;
        rx_sel = delayed_timing_i ? rx_slot_i : '0;
        sh = {s.ctl_shift[6:0], ci};
        captured = s.latch_val;
        rd = 8'h00;
        next_s = s;
        next_s.bclk_prev = bclk;
        next_s.control_clock_prev = control_clock;
        next_s.tx_taken = 1'b0;
        next_s.rx_valid = 1'b0;
        next_s.wr_pulse = 1'b0;

        // Delayed timing: sync high at a falling edge, after low at the one before, arms the next rising edge.
        if (bclk_fall)
        begin
            next_s.tx_fs_fall_prev = transmit_frame_sync;
            next_s.rx_fs_fall_prev = receive_frame_sync;
            if (transmit_frame_sync && !s.tx_fs_fall_prev)
            begin
                next_s.tx_pend = 1'b1;
            end
            if (receive_frame_sync && !s.rx_fs_fall_prev)
            begin
                next_s.rx_pend = 1'b1;
            end
        end

        if (bclk_rise)
        begin
            // [RL1] Transmit frame start.
            tx_start = delayed_timing_i ? s.tx_pend : (transmit_frame_sync && !s.tx_fs_rise_prev);
            // [RL2] Receive frame start.
            rx_start = delayed_timing_i ? s.rx_pend : (receive_frame_sync && !s.rx_fs_rise_prev);
            next_s.tx_fs_rise_prev = transmit_frame_sync;
            next_s.rx_fs_rise_prev = receive_frame_sync;
            next_s.tx_pend = 1'b0;
            next_s.rx_pend = 1'b0;
            next_s.tx_cnt = tx_start ? '0 :
                (s.tx_cnt == `SLOT_CNT_MAX) ? `SLOT_CNT_MAX : `SLOT_CNT_W'(s.tx_cnt + 1'b1);
            next_s.rx_cnt = rx_start ? '0 :
                (s.rx_cnt == `SLOT_CNT_MAX) ? `SLOT_CNT_MAX : `SLOT_CNT_W'(s.rx_cnt + 1'b1);
            // [RL19] Eight bits per slot.
            tx_act = next_s.tx_cnt[9:3] == {1'b0, tx_sel};
            // [RL6] Shift out on rise.
            if (tx_act && next_s.tx_cnt[2:0] == 3'h0)
            begin
                next_s.tx_byte = tx_sample_i;
                next_s.tx_taken = 1'b1;
                next_s.tx_out = tx_sample_i[7];
            end
            else if (tx_act)
            begin
                next_s.tx_out = s.tx_byte[3'(`SLOT_LAST_BIT - next_s.tx_cnt[2:0])];
            end
            // [RL5] Drive only in slot.
            // [RL18] Float when powered down.
            next_s.tx_oe = tx_act && !s.power_down;
        end

        // [RL8] Sample own slot on fall.
        if (bclk_fall)
        begin
            rx_act = s.rx_cnt[9:3] == {1'b0, rx_sel};
            if (rx_act)
            begin
                next_s.rx_shift = {s.rx_shift[6:0], dr};
                if (s.rx_cnt[2:0] == `SLOT_LAST_BIT)
                begin
                    next_s.rx_data = {s.rx_shift[6:0], dr};
                    next_s.rx_valid = 1'b1;
                end
            end
        end

        if (s.power_down)
        begin
            next_s.tx_oe = 1'b0;
        end

        // [RL9] Shift only with select low.
        if (cs_n)
        begin
            next_s.ctl_phase = pcm_slot_pkg::CTL_CMD;
            next_s.ctl_bits = 3'h0;
            next_s.ctl_oe = 1'b0;
        end
        else if (control_clock_fall)
        begin
            next_s.ctl_bits = 3'(s.ctl_bits + 1'b1);
            unique case (s.ctl_phase)
                pcm_slot_pkg::CTL_CMD:
                begin
                    // [RL16] Most significant bit first.
                    next_s.ctl_shift = sh;
                    // [RL10] First byte is written.
                    if (s.ctl_bits == `CTL_LAST_BIT)
                    begin
                        next_s.ctl_cmd = sh;
                        // [RL17] Power control flag.
                        next_s.power_down = sh[`CTL_PWR_BIT];
                        // [RL14] Capture input latches.
                        for (int i = 0; i < `LATCH_COUNT; i++)
                        begin
                            captured[i] = s.latch_dir[i] ? s.latch_val[i] : latch_in[i];
                        end
                        next_s.latch_val = captured;
                        if (sh[`CTL_ADDR_HI:`CTL_ADDR_LO] == `ADDR_LATCH_VAL)
                        begin
                            rd[`LATCH_FIELD_HI:`LATCH_FIELD_LO] = captured;
                        end
                        else if (sh[`CTL_ADDR_HI:`CTL_ADDR_LO] == `ADDR_LATCH_DIR)
                        begin
                            rd[`LATCH_FIELD_HI:`LATCH_FIELD_LO] = s.latch_dir;
                        end
                        else
                        begin
                            rd = ctl_read_data_i;
                        end
                        // [RL11] Bit 2 picks direction.
                        if (!sh[`CTL_TWO_BYTE_BIT])
                        begin
                            next_s.ctl_phase = pcm_slot_pkg::CTL_DONE;
                        end
                        else if (sh[`CTL_RD_BIT])
                        begin
                            next_s.ctl_phase = pcm_slot_pkg::CTL_READ;
                            next_s.ctl_shift = rd;
                            next_s.ctl_oe = 1'b1;
                        end
                        else
                        begin
                            next_s.ctl_phase = pcm_slot_pkg::CTL_WRITE;
                        end
                    end
                end
                pcm_slot_pkg::CTL_WRITE:
                begin
                    next_s.ctl_shift = sh;
                    if (s.ctl_bits == `CTL_LAST_BIT)
                    begin
                        next_s.ctl_phase = pcm_slot_pkg::CTL_DONE;
                        // [RL15] Store output latch data.
                        if (s.ctl_cmd[`CTL_ADDR_HI:`CTL_ADDR_LO] == `ADDR_LATCH_VAL)
                        begin
                            next_s.latch_val = sh[`LATCH_FIELD_HI:`LATCH_FIELD_LO];
                        end
                        // [RL13] Store latch directions.
                        else if (s.ctl_cmd[`CTL_ADDR_HI:`CTL_ADDR_LO] == `ADDR_LATCH_DIR)
                        begin
                            next_s.latch_dir = sh[`LATCH_FIELD_HI:`LATCH_FIELD_LO];
                        end
                        else
                        begin
                            next_s.wr_pulse = 1'b1;
                            next_s.wr_addr = s.ctl_cmd[`CTL_ADDR_HI:`CTL_ADDR_LO];
                            next_s.wr_data = sh;
                        end
                    end
                end
                pcm_slot_pkg::CTL_READ:
                begin
                    // [RL12] Shift read data out.
                    next_s.ctl_shift = {s.ctl_shift[6:0], 1'b0};
                    if (s.ctl_bits == `CTL_LAST_BIT)
                    begin
                        next_s.ctl_phase = pcm_slot_pkg::CTL_DONE;
                    end
                end
                pcm_slot_pkg::CTL_DONE:
                begin
                    next_s.ctl_bits = 3'h0;
                end
                default:
                begin
                    next_s.ctl_phase = pcm_slot_pkg::CTL_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s <= '0;
            s.tx_cnt <= `SLOT_CNT_MAX;
            s.rx_cnt <= `SLOT_CNT_MAX;
            s.ctl_phase <= pcm_slot_pkg::CTL_CMD;
            s.power_down <= `PWR_DOWN_RST;
            s.latch_dir <= `LATCH_DIR_RST;
            s.latch_val <= `LATCH_VAL_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign transmit_pcm_out_o = s.tx_out;
    assign transmit_pcm_out_oe_o = s.tx_oe;
    // [RL7] Strobe low in slot.
    assign transmit_slot_strobe_n_o = 1'b0;
    assign transmit_slot_strobe_n_oe_o = s.tx_oe;
    assign tx_sample_taken_o = s.tx_taken;
    assign rx_sample_o = s.rx_data;
    assign rx_sample_valid_o = s.rx_valid;
    assign control_serial_out_o = s.ctl_shift[7];
    assign control_serial_out_oe_o = s.ctl_oe;
    assign ctl_write_o = s.wr_pulse;
    assign ctl_write_addr_o = s.wr_addr;
    assign ctl_write_data_o = s.wr_data;
    assign power_down_o = s.power_down;
    // [RL13] Direction drives enables.
    assign interface_latch_pins_o = s.latch_val;
    assign interface_latch_pins_oe_o = s.latch_dir;

endmodule // pcm_slot_and_control_port
`default_nettype wire

// *** sim/pcm_slot_and_control_port_properties.sv ***
// Concurrent checks on the pins of the PCM slot and control port block.
`include "pcm_slot_defines.svh"
`default_nettype none
module pcm_port_checker (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Watched inputs.
    input wire logic chip_select_n_i,
    input wire logic [7:0] tx_sample_i,
    // Watched outputs.
    input wire logic transmit_pcm_out_o,
    input wire logic transmit_pcm_out_oe_o,
    input wire logic transmit_slot_strobe_n_o,
    input wire logic transmit_slot_strobe_n_oe_o,
    input wire logic tx_sample_taken_o,
    input wire logic rx_sample_valid_o,
    input wire logic control_serial_out_oe_o,
    input wire logic ctl_write_o,
    input wire logic [2:0] ctl_write_addr_o,
    input wire logic power_down_o,
    input wire logic [`LATCH_COUNT-1:0] interface_latch_pins_o,
    input wire logic [`LATCH_COUNT-1:0] interface_latch_pins_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    strobe_match_a: assert property (transmit_slot_strobe_n_oe_o == transmit_pcm_out_oe_o)
        else $error("slot strobe enable differs from data enable");
    strobe_low_a: assert property (transmit_slot_strobe_n_oe_o |-> !transmit_slot_strobe_n_o)
        else $error("slot strobe not pulled low");
    power_float_a: assert property (power_down_o [*2] |-> !transmit_pcm_out_oe_o)
        else $error("transmit output driven while powered down");
    slot_start_a: assert property ($rose(transmit_pcm_out_oe_o) |-> tx_sample_taken_o)
        else $error("transmit output driven without a slot start");
    first_bit_a: assert property (tx_sample_taken_o |->
        transmit_pcm_out_o == tx_sample_i[7] && transmit_pcm_out_oe_o == !$past(power_down_o))
        else $error("slot does not open with the top bit");
    slot_len_a: assert property ($rose(transmit_pcm_out_oe_o) |->
        ##120 transmit_pcm_out_oe_o ##[4:12] !transmit_pcm_out_oe_o)
        else $error("transmit slot length wrong");
    select_idle_a: assert property (chip_select_n_i [*8] |-> !control_serial_out_oe_o)
        else $error("control output driven without select");
    latch_hold_a: assert property (chip_select_n_i [*8] |->
        $stable(interface_latch_pins_o) && $stable(interface_latch_pins_oe_o))
        else $error("latch pins changed without a transaction");
    power_hold_a: assert property (chip_select_n_i [*8] |-> $stable(power_down_o))
        else $error("power state changed without a transaction");
    write_pulse_a: assert property (ctl_write_o |->
        (ctl_write_addr_o != `ADDR_LATCH_VAL && ctl_write_addr_o != `ADDR_LATCH_DIR) ##1 !ctl_write_o)
        else $error("bad register write strobe");
    rx_pulse_a: assert property (rx_sample_valid_o |=> !rx_sample_valid_o [*8])
        else $error("receive valid repeated too soon");
endmodule // pcm_port_checker
`default_nettype wire

// *** sim/pcm_bus_model.sv ***
// Behavioural PCM backplane giving bit clock, frame syncs and slot data.
`default_nettype none
module pcm_bus_model (
    // PCM bus pins.
    output logic bit_clock_o,
    output logic tx_sync_o,
    output logic rx_sync_o,
    output logic rx_pcm_o,
    input wire logic tx_pcm_i,
    input wire logic tx_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    int n;
    int first_bit;
    logic [7:0] got;
    initial
    begin
        bit_clock_o = 1'b0;
        tx_sync_o = 1'b0;
        rx_sync_o = 1'b0;
        rx_pcm_o = 1'b0;
        #1.3;
        forever #32 bit_clock_o = ~bit_clock_o;
    end
    // Sends one frame and records what the block drives.
    task automatic frame(input logic [7:0] rx_byte, input int rx_slot);
        int i;
        n = 0;
        first_bit = -1;
        got = 8'h00;
        @(posedge bit_clock_o);
        #16;
        // Syncs rise between bit clock rises.
        tx_sync_o = 1'b1;
        rx_sync_o = 1'b1;
        for (i = 0; i < 49; i++)
        begin
            @(posedge bit_clock_o);
            if (i > 0 && tx_oe_i === 1'b1)
            begin
                if (first_bit < 0)
                    first_bit = i - 1;
                got = {got[6:0], tx_pcm_i};
                n++;
            end
            #16;
            tx_sync_o = 1'b0;
            rx_sync_o = 1'b0;
            // Data is only meaningful in the receive slot.
            if (i / 8 == rx_slot)
                rx_pcm_o = rx_byte[7-i%8];
            else
                rx_pcm_o = ~rx_pcm_o;
        end
    endtask
endmodule // pcm_bus_model
`default_nettype wire

// *** sim/pcm_slot_and_control_port_tb_top.sv ***
// Self-checking bench for the PCM slot and control port block.
`include "pcm_slot_defines.svh"
`default_nettype none
module pcm_slot_and_control_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_i, rst_n_i, delayed_timing_i, bit_clock_i, transmit_frame_sync_i, receive_frame_sync_i;
    logic [`SLOT_NUM_W-1:0] tx_slot_i, rx_slot_i;
    logic receive_pcm_in_i, transmit_pcm_out_o, transmit_pcm_out_oe_o;
    logic transmit_slot_strobe_n_o, transmit_slot_strobe_n_oe_o, tx_sample_taken_o, rx_sample_valid_o;
    logic [7:0] tx_sample_i, rx_sample_o, ctl_read_data_i, ctl_write_data_o, rd;
    logic control_clock_i, chip_select_n_i, control_serial_in_i, control_serial_out_o, control_serial_out_oe_o;
    logic ctl_write_o, power_down_o;
    logic [2:0] ctl_write_addr_o;
    logic [`LATCH_COUNT-1:0] interface_latch_pins_i, interface_latch_pins_o, interface_latch_pins_oe_o;
    int n_errors, check_count, cycles, n_wr, n_rx;
    pcm_slot_and_control_port dut_u (.sys_clk_i, .rst_n_i, .delayed_timing_i, .tx_slot_i, .rx_slot_i,
        .bit_clock_i, .transmit_frame_sync_i, .receive_frame_sync_i, .receive_pcm_in_i, .transmit_pcm_out_o,
        .transmit_pcm_out_oe_o, .transmit_slot_strobe_n_o, .transmit_slot_strobe_n_oe_o, .tx_sample_i,
        .tx_sample_taken_o, .rx_sample_o, .rx_sample_valid_o, .control_clock_i, .chip_select_n_i,
        .control_serial_in_i, .control_serial_out_o, .control_serial_out_oe_o, .ctl_read_data_i, .ctl_write_o,
        .ctl_write_addr_o, .ctl_write_data_o, .power_down_o, .interface_latch_pins_i, .interface_latch_pins_o,
        .interface_latch_pins_oe_o);
    pcm_bus_model bus_u (.bit_clock_o(bit_clock_i), .tx_sync_o(transmit_frame_sync_i),
        .rx_sync_o(receive_frame_sync_i), .rx_pcm_o(receive_pcm_in_i), .tx_pcm_i(transmit_pcm_out_o),
        .tx_oe_i(transmit_pcm_out_oe_o));
    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i)
    begin
        cycles++;
        n_wr += (ctl_write_o === 1'b1);
        n_rx += (rx_sample_valid_o === 1'b1);
        if (cycles == 30000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Host transfer of nb control bits, collecting read-back bits in rd.
    task automatic ctl(input logic [7:0] b1, input logic [7:0] b2, input int nb);
        int i;
        logic [15:0] w;
        w = {b1, b2};
        rd = 8'h00;
        @(posedge sys_clk_i);
        chip_select_n_i <= 1'b0;
        for (i = 0; i < nb; i++)
        begin
            repeat (12) @(posedge sys_clk_i);
            control_clock_i <= 1'b1;
            control_serial_in_i <= w[15-i];
            repeat (12) @(posedge sys_clk_i);
            if (i >= 8)
                rd = {rd[6:0], control_serial_out_o};
            control_clock_i <= 1'b0;
        end
        repeat (12) @(posedge sys_clk_i);
        chip_select_n_i <= 1'b1;
        repeat (12) @(posedge sys_clk_i);
    endtask
    task automatic t_reset();
        check({transmit_pcm_out_oe_o, control_serial_out_oe_o, interface_latch_pins_oe_o}, 32'h0);
        check(power_down_o, 32'h1);
    endtask
    task automatic t_power_up();
        ctl(8'h00, 8'h00, 8);
        check(power_down_o, 32'h0);
    endtask
    task automatic t_plain_frame();
        tx_sample_i <= 8'ha5;
        bus_u.frame(8'h3c, 0);
        check(bus_u.got, 32'ha5);
        check(bus_u.n, 32'h8);
        check(bus_u.first_bit, 32'h0);
        check(rx_sample_o, 32'h3c);
        check(n_rx, 32'h1);
    endtask
    task automatic t_slot_frame();
        delayed_timing_i <= 1'b1;
        tx_slot_i <= 6'h02;
        rx_slot_i <= 6'h04;
        tx_sample_i <= 8'h69;
        repeat (4) @(posedge sys_clk_i);
        bus_u.frame(8'hc6, 4);
        check(bus_u.got, 32'h69);
        check(bus_u.first_bit, 32'h10);
        check(rx_sample_o, 32'hc6);
        check(n_rx, 32'h2);
    endtask
    task automatic t_other_regs();
        ctl_read_data_i <= 8'hc3;
        ctl(8'h22, 8'h5a, 16);
        check({ctl_write_addr_o, ctl_write_data_o}, {3'h4, 8'h5a});
        ctl(8'h26, 8'h00, 16);
        check(rd, 32'hc3);
        check(n_wr, 32'h1);
    endtask
    task automatic t_power_down();
        ctl(8'h80, 8'h00, 8);
        check(power_down_o, 32'h1);
        tx_sample_i <= 8'hff;
        bus_u.frame(8'h00, 0);
        check(bus_u.n, 32'h0);
    endtask
    task automatic t_latches();
        ctl(8'h92, 8'ha0, 16);
        ctl(8'h8a, 8'hf0, 16);
        check(interface_latch_pins_oe_o, 32'ha);
        check(interface_latch_pins_o & 4'ha, 32'ha);
        interface_latch_pins_i <= 4'h4;
        ctl(8'h8e, 8'h00, 16);
        check({rd[7:4] & 4'h5, rd[3:0]}, 32'h40);
        ctl(8'h96, 8'h00, 16);
        check(rd, 32'ha0);
        ctl(8'h8a, 8'h00, 16);
        check(interface_latch_pins_o & 4'ha, 32'h0);
        check(power_down_o, 32'h1);
    endtask
    task automatic t_abort();
        ctl(8'ha2, 8'h11, 12);
        check(n_wr, 32'h1);
        check(ctl_write_data_o, 32'h5a);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        sys_clk_i = 1'b0;
        rst_n_i = 1'b0;
        delayed_timing_i = 1'b0;
        tx_slot_i = 6'h00;
        rx_slot_i = 6'h00;
        tx_sample_i = 8'h00;
        ctl_read_data_i = 8'h00;
        control_clock_i = 1'b0;
        chip_select_n_i = 1'b1;
        control_serial_in_i = 1'b0;
        interface_latch_pins_i = 4'h0;
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        t_reset();
        t_power_up();
        t_plain_frame();
        t_slot_frame();
        t_other_regs();
        t_power_down();
        t_latches();
        t_abort();
        print_verdict();
    end
endmodule // pcm_slot_and_control_port_tb_top
bind pcm_slot_and_control_port pcm_port_checker chk_u (.sys_clk_i, .rst_n_i, .chip_select_n_i, .tx_sample_i,
    .transmit_pcm_out_o, .transmit_pcm_out_oe_o, .transmit_slot_strobe_n_o, .transmit_slot_strobe_n_oe_o,
    .tx_sample_taken_o, .rx_sample_valid_o, .control_serial_out_oe_o, .ctl_write_o, .ctl_write_addr_o,
    .power_down_o, .interface_latch_pins_o, .interface_latch_pins_oe_o);
`default_nettype wire
